/* logic/output_relay_control.sv */
// Output relay control: bus registers, acknowledge, disarm, force, health
//
// What this block does
// - Latched outputs regain their stored position after a power loss.
// - A latched output keeps its state through any reconfiguration.
// - Only an acknowledge releases a latched output.
// - The panel clear key acknowledges the outputs.
// - Per-output acknowledge input counts only while that output latches.
// - Rising external group acknowledge acknowledges all outputs at once.
// - Supervisory link group acknowledge clears all outputs together.
// - Health contact has no settings; energized only without internal fault.
// - Health contact stays off during boot.
// - After good start-up, health contact and its LED turn on.
// - Disarm needs the disarm control enabled before the disarm command.
// - Disarm skips outputs that are latched or inside their hold time.
// - Exempt outputs (zone interlock, supervision) are never disarmed.
// - Each relay forces normal, de-energized or energized; normal default.
// - A de-energized or energized group force overrides every single relay force.
// - Output is OR of the selected ones of seven optionally inverted signals, optionally inverted.
// - Acknowledge works only once the cause cleared and hold elapsed.
// - Each channel state transition is held for hold_ticks timer ticks; forces and disarm switch the coil without hold.
`timescale 1ns/1ps
module output_relay_control #(
  parameter int NUM_RELAYS = 5,
  parameter int TICK_CYCLES = relay_ctrl_pkg::TICK_CYCLES,
  parameter logic [7:0] DISARM_EXEMPT = 8'h00
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Avalon-MM slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Protection signals, seven per relay
  input wire logic [NUM_RELAYS*7-1:0] prot_sig,
  // Acknowledge sources
  input wire logic panel_clear_key,
  input wire logic [NUM_RELAYS-1:0] relay_ack_in,
  input wire logic external_group_ack,
  // Device health
  input wire logic boot_ok,
  input wire logic internal_fault,
  // Retained latch storage
  input wire logic [NUM_RELAYS-1:0] nv_latch_in,
  output logic [NUM_RELAYS-1:0] nv_latch_out,
  output logic nv_store,
  // Relay coils and health indication
  output logic [NUM_RELAYS-1:0] relay_coil,
  output logic health_contact,
  output logic health_led
);
  // ***************************************************
  // Parameter checks
  // ***************************************************
  if (NUM_RELAYS < 1 || NUM_RELAYS > 8) begin : g_bad_relays
    $error("NUM_RELAYS must be 1 to 8");
  end
  if (TICK_CYCLES < 1) begin : g_bad_tick
    $error("TICK_CYCLES must be at least 1");
  end

  localparam int TW = $clog2(TICK_CYCLES + 1);
  localparam int N = NUM_RELAYS;
  localparam int HW = relay_ctrl_pkg::HOLD_W;

  // ***************************************************
  // State
  // ***************************************************
  typedef struct packed {
    logic wait_q;
    logic [31:0] rdata;
    logic [N-1:0] latch_en;
    logic [N-1:0] out_inv;
    logic [N-1:0][6:0] sel;
    logic [N-1:0][6:0] sinv;
    logic [N-1:0][HW-1:0] hold;
    logic [N-1:0][1:0] force_sel;
    logic [1:0] gforce;
    logic dis_en;
    logic dis_cmd;
    logic [N-1:0] disarmed;
    logic link_ack;
    logic ext_prev;
    logic [TW-1:0] tick_cnt;
    logic tick;
    logic restored;
    logic [N-1:0] nv_out;
    logic nv_store;
    logic [N-1:0] coil;
    logic health;
    logic led;
  } ctrl_state_t;

  ctrl_state_t s_q;
  ctrl_state_t s_d;

  logic [N-1:0] ch_state;
  logic [N-1:0] ch_latched;
  logic [N-1:0] ch_holding;
  logic [N-1:0] ch_ack;
  logic [N-1:0] ch_restore_val;
  logic group_ack;
  logic acc;
  logic [31:0] wdata;
  logic [1:0] eff_force;

  // ***************************************************
  // Decode helpers
  // ***************************************************
  function automatic logic is_ch(input logic [7:0] a);
    return a >= relay_ctrl_pkg::CH_BASE_OFS &&
           a < 8'(relay_ctrl_pkg::CH_BASE_OFS + N * 8);
  endfunction

  function automatic logic [2:0] ch_idx(input logic [7:0] a);
    return 3'((a - relay_ctrl_pkg::CH_BASE_OFS) >> 3);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] read_reg(input ctrl_state_t s,
                                           input logic [7:0] a,
                                           input logic [N-1:0] lat,
                                           input logic [N-1:0] hld);
    logic [31:0] r;
    logic [2:0] k;
    r = 32'h0000_0000;
    k = ch_idx(a);
    if (is_ch(a)) begin
      if (a[2]) begin
        r[HW-1:0] = s.hold[k];
      end else begin
        r[6:0] = s.sel[k];
        r[relay_ctrl_pkg::CH_INV_LSB +: 7] = s.sinv[k];
      end
    end else begin
      case (a)
        relay_ctrl_pkg::CTRL_OFS: begin
          r[relay_ctrl_pkg::CTRL_DIS_EN_BIT] = s.dis_en;
          r[relay_ctrl_pkg::CTRL_DIS_CMD_BIT] = s.dis_cmd;
          r[relay_ctrl_pkg::CTRL_GFORCE_LSB +: 2] = s.gforce;
        end
        relay_ctrl_pkg::LATCH_OFS: r[N-1:0] = s.latch_en;
        relay_ctrl_pkg::OINV_OFS: r[N-1:0] = s.out_inv;
        relay_ctrl_pkg::FORCE_OFS: r[2*N-1:0] = s.force_sel;
        relay_ctrl_pkg::STATUS_OFS: begin
          r[N-1:0] = s.coil;
          r[relay_ctrl_pkg::STAT_LATCH_LSB +: N] = lat;
          r[relay_ctrl_pkg::STAT_DIS_LSB +: N] = s.disarmed;
          r[relay_ctrl_pkg::STAT_HEALTH_BIT] = s.health;
        end
        relay_ctrl_pkg::HOLDING_OFS: r[N-1:0] = hld;
        default: r = 32'h0000_0000;
      endcase
    end
    return r;
  endfunction

  // ***************************************************
  // Reset image
  // ***************************************************
  function automatic ctrl_state_t rst_image();
    ctrl_state_t r = '0;
    r.wait_q = 1'b1;
    r.latch_en = relay_ctrl_pkg::LATCH_RST[N-1:0];
    r.out_inv = relay_ctrl_pkg::OINV_RST[N-1:0];
    for (int i = 0; i < N; i++) begin
      r.sel[i] = relay_ctrl_pkg::SEL_RST;
      r.sinv[i] = relay_ctrl_pkg::SINV_RST;
      r.hold[i] = relay_ctrl_pkg::HOLD_RST;
      r.force_sel[i] = relay_ctrl_pkg::FORCE_NORMAL;
    end
    r.gforce = relay_ctrl_pkg::FORCE_NORMAL;
    return r;
  endfunction

  // ***************************************************
  // Acknowledge merge
  // ***************************************************
  // Key and per-output inputs act on the same cycle, the link one cycle after its write; external input acts on its rise
  assign group_ack = panel_clear_key |
                     (external_group_ack & ~s_q.ext_prev) |
                     s_q.link_ack;
  assign ch_ack = {N{group_ack}} | (relay_ack_in & s_q.latch_en);
  assign ch_restore_val = nv_latch_in & s_q.latch_en;

  // ***************************************************
  // Relay channels
  // ***************************************************
  for (genvar g = 0; g < N; g++) begin : g_ch
    relay_channel u_ch (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .tick(s_q.tick),
      .sig(prot_sig[g*7 +: 7]),
      .sel(s_q.sel[g]),
      .sig_inv(s_q.sinv[g]),
      .out_inv(s_q.out_inv[g]),
      .latch_en(s_q.latch_en[g]),
      .hold_ticks(s_q.hold[g]),
      .ack(ch_ack[g]),
      .restore(~s_q.restored),
      .restore_val(ch_restore_val[g]),
      .state(ch_state[g]),
      .latched(ch_latched[g]),
      .holding(ch_holding[g])
    );
  end

  // ***************************************************
  // Next state
  // ***************************************************
  assign acc = (avs_read | avs_write) & ~s_q.wait_q;

  always_comb begin
    s_d = s_q;
    wdata = 32'h0000_0000;
    eff_force = relay_ctrl_pkg::FORCE_NORMAL;
    // Bus: one wait cycle, then the access completes
    s_d.wait_q = ~((avs_read | avs_write) & s_q.wait_q);
    s_d.rdata = read_reg(s_q, avs_address, ch_latched, ch_holding);
    s_d.link_ack = 1'b0;
    s_d.ext_prev = external_group_ack;

    // Fixed timer tick
    if (s_q.tick_cnt == TW'(TICK_CYCLES - 1)) begin
      s_d.tick_cnt = '0;
      s_d.tick = 1'b1;
    end else begin
      s_d.tick_cnt = s_q.tick_cnt + 1'b1;
      s_d.tick = 1'b0;
    end

    if (acc && avs_write) begin
      if (is_ch(avs_address)) begin
        if (avs_address[2]) begin
          wdata = merge({17'h0, s_q.hold[ch_idx(avs_address)]},
                        avs_writedata, avs_byteenable);
          s_d.hold[ch_idx(avs_address)] = wdata[HW-1:0];
        end else begin
          wdata = merge({17'h0, s_q.sinv[ch_idx(avs_address)], 1'b0,
                         s_q.sel[ch_idx(avs_address)]},
                        avs_writedata, avs_byteenable);
          s_d.sel[ch_idx(avs_address)] = wdata[6:0];
          s_d.sinv[ch_idx(avs_address)] =
            wdata[relay_ctrl_pkg::CH_INV_LSB +: 7];
        end
      end else begin
        wdata = merge(read_reg(s_q, avs_address, ch_latched, ch_holding),
                      avs_writedata, avs_byteenable);
        case (avs_address)
          relay_ctrl_pkg::CTRL_OFS: begin
            s_d.dis_en = wdata[relay_ctrl_pkg::CTRL_DIS_EN_BIT];
            s_d.gforce = wdata[relay_ctrl_pkg::CTRL_GFORCE_LSB +: 2];
            s_d.link_ack = wdata[relay_ctrl_pkg::CTRL_ACK_BIT];
            if (!wdata[relay_ctrl_pkg::CTRL_DIS_CMD_BIT]) begin
              s_d.dis_cmd = 1'b0;
              s_d.disarmed = '0;
            end else if (s_q.dis_en) begin
              // Command is refused unless the control was already on
              s_d.dis_cmd = 1'b1;
              s_d.disarmed = s_q.disarmed | (~ch_latched &
                ~ch_holding & ~DISARM_EXEMPT[N-1:0]);
            end
          end
          relay_ctrl_pkg::LATCH_OFS: s_d.latch_en = wdata[N-1:0];
          relay_ctrl_pkg::OINV_OFS: s_d.out_inv = wdata[N-1:0];
          relay_ctrl_pkg::FORCE_OFS: s_d.force_sel = wdata[2*N-1:0];
          default: s_d.dis_cmd = s_q.dis_cmd;
        endcase
      end
    end
    // Dropping the control re-arms everything
    if (!s_d.dis_en) begin
      s_d.dis_cmd = 1'b0;
      s_d.disarmed = '0;
    end

    // Coil drive with force priority
    for (int i = 0; i < N; i++) begin
      if (s_q.gforce == relay_ctrl_pkg::FORCE_DEENERGIZED ||
          s_q.gforce == relay_ctrl_pkg::FORCE_ENERGIZED) begin
        eff_force = s_q.gforce;
      end else begin
        eff_force = s_q.force_sel[i];
      end
      case (eff_force)
        relay_ctrl_pkg::FORCE_ENERGIZED: s_d.coil[i] = 1'b1;
        relay_ctrl_pkg::FORCE_DEENERGIZED: s_d.coil[i] = 1'b0;
        default: s_d.coil[i] = ch_state[i] & ~s_q.disarmed[i];
      endcase
    end

    // Retained storage follows the latch image after restore
    s_d.restored = 1'b1;
    s_d.nv_out = ch_latched;
    s_d.nv_store = s_q.restored && ch_latched != s_q.nv_out;

    // Health contact: no settings, off in boot, on when healthy
    s_d.health = boot_ok & ~internal_fault;
    s_d.led = boot_ok & ~internal_fault;
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= rst_image();
    end else begin
      s_q <= s_d;
    end
  end

  // ***************************************************
  // Outputs
  // ***************************************************
  assign avs_readdata = s_q.rdata;
  assign avs_waitrequest = s_q.wait_q;
  assign nv_latch_out = s_q.nv_out;
  assign nv_store = s_q.nv_store;
  assign relay_coil = s_q.coil;
  assign health_contact = s_q.health;
  assign health_led = s_q.led;
endmodule // output_relay_control

/* logic/relay_ctrl_pkg.sv */
// Package of register map, field layout and timing for relay control
package relay_ctrl_pkg;
  // ***************************************************
  // Register offsets (byte addresses)
  // ***************************************************
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] LATCH_OFS = 8'h04;
  localparam logic [7:0] OINV_OFS = 8'h08;
  localparam logic [7:0] FORCE_OFS = 8'h0c;
  localparam logic [7:0] STATUS_OFS = 8'h10;
  localparam logic [7:0] HOLDING_OFS = 8'h14;
  localparam logic [7:0] CH_BASE_OFS = 8'h20;
  localparam logic [7:0] CH_STRIDE = 8'h08;
  localparam logic [7:0] CH_HOLD_OFS = 8'h04;

  // ***************************************************
  // Field positions
  // ***************************************************
  localparam int CTRL_DIS_EN_BIT = 0;
  localparam int CTRL_DIS_CMD_BIT = 1;
  localparam int CTRL_ACK_BIT = 2;
  localparam int CTRL_GFORCE_LSB = 4;
  localparam int STAT_LATCH_LSB = 8;
  localparam int STAT_DIS_LSB = 16;
  localparam int STAT_HEALTH_BIT = 24;
  localparam int CH_INV_LSB = 8;
  localparam int SIG_PER_RELAY = 7;
  localparam int HOLD_W = 15;

  // ***************************************************
  // Reset values
  // ***************************************************
  localparam logic [7:0] LATCH_RST = 8'hff;
  localparam logic [7:0] OINV_RST = 8'h00;
  localparam logic [6:0] SEL_RST = 7'h00;
  localparam logic [6:0] SINV_RST = 7'h00;
  localparam logic [HOLD_W-1:0] HOLD_RST = 15'h0000;

  // ***************************************************
  // Timing
  // ***************************************************
  localparam int CLK_PERIOD_NS = 25;
  localparam int TICK_NS = 10000000;
  localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;

  // ***************************************************
  // Force settings
  // ***************************************************
  typedef enum logic [1:0] {
    FORCE_NORMAL = 2'b00,
    FORCE_DEENERGIZED = 2'b01,
    FORCE_ENERGIZED = 2'b10
  } force_t;
endpackage

/* logic/relay_channel.sv */
// One output relay channel: signal combine, latch, hold timer
`timescale 1ns/1ps
module relay_channel (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Timing
  input wire logic tick,
  // Assigned signals and their setup
  input wire logic [6:0] sig,
  input wire logic [6:0] sel,
  input wire logic [6:0] sig_inv,
  input wire logic out_inv,
  input wire logic latch_en,
  input wire logic [relay_ctrl_pkg::HOLD_W-1:0] hold_ticks,
  // Acknowledge and restore
  input wire logic ack,
  input wire logic restore,
  input wire logic restore_val,
  // State
  output logic state,
  output logic latched,
  output logic holding
);
  typedef struct packed {
    logic state;
    logic latched;
    logic [relay_ctrl_pkg::HOLD_W-1:0] hold_cnt;
  } ch_state_t;

  ch_state_t s_q;
  ch_state_t s_d;
  logic raw;
  logic desired;

  always_comb begin
    raw = (|(sel & (sig ^ sig_inv))) ^ out_inv;
    desired = raw | s_q.latched;
    s_d = s_q;
    if (restore) begin
      // Stored position comes back instead of a cleared one
      s_d.state = restore_val;
      s_d.latched = restore_val;
    end else begin
      if (latch_en && raw) begin
        s_d.latched = 1'b1;
      end else if (ack && !raw && s_q.hold_cnt == '0) begin
        // Latch drops only by acknowledge, never by config change
        s_d.latched = 1'b0;
      end
      if (desired != s_q.state && s_q.hold_cnt == '0) begin
        s_d.state = desired;
        s_d.hold_cnt = hold_ticks;
      end else if (tick && s_q.hold_cnt != '0) begin
        s_d.hold_cnt = s_q.hold_cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign state = s_q.state;
  assign latched = s_q.latched;
  assign holding = s_q.hold_cnt != '0;
endmodule // relay_channel

/* bench/output_relay_control_chk.sv */
// Assertion checker for the output relay control block
`timescale 1ns/1ps
module output_relay_control_chk #(
  parameter int NUM_RELAYS = 5
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Register bus
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic avs_waitrequest,
  // Acknowledge sources and health inputs
  input wire logic panel_clear_key,
  input wire logic [NUM_RELAYS-1:0] relay_ack_in,
  input wire logic external_group_ack,
  input wire logic boot_ok,
  input wire logic internal_fault,
  // Outputs
  input wire logic [NUM_RELAYS-1:0] nv_latch_out,
  input wire logic nv_store,
  input wire logic health_contact,
  input wire logic health_led
);
  logic [5:0] ack_hist_q;
  logic [5:0] ack_hist_d;
  logic link_ack;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  always_comb begin
    link_ack = avs_write && avs_byteenable[0]
      && avs_address == relay_ctrl_pkg::CTRL_OFS
      && avs_writedata[relay_ctrl_pkg::CTRL_ACK_BIT];
    ack_hist_d = {ack_hist_q[4:0], panel_clear_key | (|relay_ack_in)
      | external_group_ack | link_ack};
  end

  // Reset fills the history: the restore may drop bits just after release
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ack_hist_q <= 6'h3f;
    end else begin
      ack_hist_q <= ack_hist_d;
    end
  end

  // ********************************
  // Properties
  // ********************************
  property p_latch_ack;
    |(~nv_latch_out & $past(nv_latch_out)) |-> |ack_hist_q;
  endproperty
  a_latch_ack: assert property (p_latch_ack)
    else $error("latched output released without acknowledge");
  property p_health_on;
    boot_ok && !internal_fault |=> health_contact;
  endproperty
  a_health_on: assert property (p_health_on)
    else $error("health contact not energized");
  property p_health_fault;
    internal_fault |=> !health_contact;
  endproperty
  a_health_fault: assert property (p_health_fault)
    else $error("health contact on during fault");
  property p_health_boot;
    !boot_ok |=> !health_contact;
  endproperty
  a_health_boot: assert property (p_health_boot)
    else $error("health contact on during boot");
  property p_led;
    health_led == health_contact;
  endproperty
  a_led: assert property (p_led)
    else $error("health indicator differs from contact");
  property p_nv_store;
    nv_store == (nv_latch_out != $past(nv_latch_out));
  endproperty
  a_nv_store: assert property (p_nv_store)
    else $error("retained store pulse does not match image change");
  property p_wait_ans;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wait_ans: assert property (p_wait_ans)
    else $error("bus access not answered");
  property p_wait_one;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one)
    else $error("waitrequest low too long");
  property p_wait_idle;
    !(avs_read || avs_write) |=> avs_waitrequest;
  endproperty
  a_wait_idle: assert property (p_wait_idle)
    else $error("waitrequest low without access");
endmodule // output_relay_control_chk

bind output_relay_control output_relay_control_chk #(
  .NUM_RELAYS(NUM_RELAYS)
) i_chk (
  .sys_clk(sys_clk), .reset_n(reset_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_waitrequest(avs_waitrequest), .panel_clear_key(panel_clear_key),
  .relay_ack_in(relay_ack_in), .external_group_ack(external_group_ack),
  .boot_ok(boot_ok), .internal_fault(internal_fault),
  .nv_latch_out(nv_latch_out), .nv_store(nv_store),
  .health_contact(health_contact),
  .health_led(health_led)
);

/* bench/relay_far_side.sv */
// Far-side model: protection signal sources feeding the relay block
`timescale 1ns/1ps
module relay_far_side #(
  parameter int NUM_RELAYS = 5
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Requested levels and pace
  input wire logic [NUM_RELAYS*7-1:0] want,
  input wire logic slow,
  // Protection signals
  output logic [NUM_RELAYS*7-1:0] prot_sig
);
  logic [NUM_RELAYS*7-1:0] stage_q;

  // A slow source shows a new level one clock later than a prompt one
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      stage_q <= '0;
      prot_sig <= '0;
    end else begin
      stage_q <= want;
      prot_sig <= slow ? stage_q : want;
    end
  end
endmodule // relay_far_side

/* bench/test_output_relay_control.sv */
// Self-checking testbench for the output relay control block
`timescale 1ns/1ps
module test_output_relay_control;
  localparam int N = 5;
  localparam logic [7:0] CT = relay_ctrl_pkg::CTRL_OFS;
  localparam logic [7:0] ST = relay_ctrl_pkg::STATUS_OFS;
  localparam logic [7:0] LT = relay_ctrl_pkg::LATCH_OFS;
  localparam logic [7:0] FC = relay_ctrl_pkg::FORCE_OFS;
  localparam logic [7:0] OI = relay_ctrl_pkg::OINV_OFS;
  logic sys_clk, reset_n, avs_read, avs_write, avs_waitrequest;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0] avs_byteenable;
  logic [N*7-1:0] want, prot_sig;
  logic slow, panel_clear_key, external_group_ack, boot_ok, internal_fault;
  logic [N-1:0] relay_ack_in, nv_latch_in, nv_latch_out, relay_coil, raw;
  logic nv_store, health_contact, health_led;
  logic [6:0] sel_v[N];
  logic [6:0] inv_v[N];
  logic [6:0] sig;
  logic [4:0] gx[3] = '{5'h1a, 5'h00, 5'h1f};
  logic [63:0] exp_q[$], e_v;
  int error_cnt, n_tests, seed_v;

  output_relay_control #(.NUM_RELAYS(N), .TICK_CYCLES(4),
    .DISARM_EXEMPT(8'h10)) i_dut (
    .sys_clk(sys_clk), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .prot_sig(prot_sig), .panel_clear_key(panel_clear_key),
    .relay_ack_in(relay_ack_in), .external_group_ack(external_group_ack),
    .boot_ok(boot_ok), .internal_fault(internal_fault),
    .nv_latch_in(nv_latch_in), .nv_latch_out(nv_latch_out),
    .nv_store(nv_store), .relay_coil(relay_coil),
    .health_contact(health_contact), .health_led(health_led));
  relay_far_side #(.NUM_RELAYS(N)) i_far (.sys_clk(sys_clk),
    .reset_n(reset_n), .want(want), .slow(slow), .prot_sig(prot_sig));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // ********************************
  // Bus, comparison and closing tasks
  // ********************************
  task automatic fail(input string s);
    error_cnt++;
    $display("ERROR %0t %s", $time, s);
  endtask
  task automatic end_of_test();
    if (error_cnt == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic bus(input logic r, input logic [7:0] a,
      input logic [31:0] d, input logic [31:0] m);
    if (r)
      exp_q.push_back({m, d});
    avs_address <= a;
    avs_writedata <= r ? 32'h0 : d;
    avs_read <= r;
    avs_write <= !r;
    // Only the watchdog ends a wait for the answer
    do
      @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b0, a, d, 32'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
      input logic [31:0] m);
    bus(1'b1, a, e, m);
  endtask
  task automatic sts(input logic [4:0] c, input logic [4:0] l,
      input logic [4:0] d);
    rd(ST, {11'h0, d, 3'h0, l, 3'h0, c}, 32'h001f1f1f);
  endtask
  task automatic wt(input int c);
    repeat (c) @(posedge sys_clk);
  endtask
  task automatic chk(input logic [63:0] e);
    n_tests++;
    if ((avs_readdata & e[63:32]) !== (e[31:0] & e[63:32]))
      fail("read data mismatch");
  endtask
  task automatic chk_coil(input logic [4:0] e);
    n_tests++;
    if (relay_coil !== e)
      fail("coil drive mismatch");
  endtask

  always @(posedge sys_clk) begin
    if (avs_read && avs_waitrequest === 1'b0) begin
      if (exp_q.size() == 0)
        fail("unexpected read data");
      else begin
        e_v = exp_q.pop_front();
        chk(e_v);
        if (avs_address == ST && e_v[36:32] == 5'h1f)
          chk_coil(e_v[4:0]);
      end
    end
  end

  // Generous span: the sequence needs a few hundred cycles
  initial begin
    repeat (30000) @(posedge sys_clk);
    fail("timeout");
    end_of_test();
  end

  // ********************************
  // Main sequence
  // ********************************
  initial begin
    seed_v = $urandom(32'h6626c147);
    {reset_n, avs_read, avs_write, slow, panel_clear_key} = 5'h00;
    {external_group_ack, boot_ok, internal_fault} = 3'h0;
    avs_address = 8'h00;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    want = '0;
    relay_ack_in = '0;
    nv_latch_in = 5'h03;
    repeat (12) @(posedge sys_clk);
    reset_n <= 1'b1;
    wt(4);
    sts(5'h03, 5'h03, 5'h00);
    rd(LT, 32'h1f, 32'h1f);
    rd(FC, 32'h0, 32'h3ff);
    rd(ST, 32'h0, 32'h01000000);
    wr(LT, 32'h1c);
    sts(5'h03, 5'h03, 5'h00);
    relay_ack_in <= 5'h1f;
    wt(2);
    relay_ack_in <= 5'h00;
    wt(4);
    sts(5'h03, 5'h03, 5'h00);
    panel_clear_key <= 1'b1;
    wt(2);
    panel_clear_key <= 1'b0;
    wt(4);
    sts(5'h00, 5'h00, 5'h00);
    wr(LT, 32'h1f);
    boot_ok <= 1'b1;
    wt(3);
    rd(ST, 32'h01000000, 32'h01000000);
    internal_fault <= 1'b1;
    wt(3);
    rd(ST, 32'h0, 32'h01000000);
    internal_fault <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      slow <= k[0];
      // Latching stays off while a setup is only half written
      wr(LT, 32'h0);
      for (int i = 0; i < N; i++) begin
        sel_v[i] = 7'($urandom_range(1, 127));
        inv_v[i] = 7'($urandom());
        sig = 7'($urandom());
        wr(8'h20 + 8'(8 * i), {17'h0, inv_v[i], 1'b0, sel_v[i]});
        want[7*i +: 7] <= sig;
        raw[i] = |(sel_v[i] & (sig ^ inv_v[i]));
      end
      wt(8);
      wr(LT, 32'h1f);
      sts(raw, raw, 5'h00);
      panel_clear_key <= 1'b1;
      wt(2);
      panel_clear_key <= 1'b0;
      for (int i = 0; i < N; i++)
        want[7*i +: 7] <= inv_v[i];
      wt(8);
      sts(raw, raw, 5'h00);
      case (k)
        0: panel_clear_key <= 1'b1;
        1: external_group_ack <= 1'b1;
        2: wr(CT, 32'h4);
        default: relay_ack_in <= 5'h1f;
      endcase
      wt(2);
      {panel_clear_key, external_group_ack} <= 2'b00;
      relay_ack_in <= 5'h00;
      wt(6);
      sts(5'h00, 5'h00, 5'h00);
    end
    wr(LT, 32'h0);
    slow <= 1'b0;
    want <= '0;
    for (int i = 0; i < N; i++)
      wr(8'h20 + 8'(8 * i), 32'h1);
    wr(LT, 32'h1b);
    wr(8'h34, 32'h7);
    wt(8);
    want[14] <= 1'b1;
    wt(3);
    want[14] <= 1'b0;
    wt(2);
    sts(5'h04, 5'h00, 5'h00);
    rd(relay_ctrl_pkg::HOLDING_OFS, 32'h4, 32'h1f);
    wt(40);
    sts(5'h00, 5'h00, 5'h00);
    wr(LT, 32'h07);
    want <= 35'h010200001;
    wt(8);
    want <= 35'h010200000;
    wt(8);
    wr(CT, 32'h2);
    wt(2);
    sts(5'h19, 5'h01, 5'h00);
    wr(CT, 32'h1);
    wr(CT, 32'h3);
    wt(4);
    sts(5'h11, 5'h01, 5'h0e);
    wr(CT, 32'h0);
    wt(4);
    sts(5'h19, 5'h01, 5'h00);
    wr(FC, 32'h9);
    for (int g = 0; g < 3; g++) begin
      wr(CT, 32'(g) << relay_ctrl_pkg::CTRL_GFORCE_LSB);
      wt(4);
      rd(ST, {27'h0, gx[g]}, 32'h1f);
    end
    wr(CT, 32'h0);
    wr(FC, 32'h0);
    rd(8'h18, 32'h0, 32'hffffffff);
    wr(ST, 32'hffffffff);
    avs_byteenable <= 4'h0;
    wr(OI, 32'hff);
    avs_byteenable <= 4'hf;
    rd(OI, 32'h0, 32'h1f);
    wr(OI, 32'h2);
    wt(6);
    rd(ST, 32'h1b, 32'h1f);
    end_of_test();
  end
endmodule // test_output_relay_control
